// [design/iwr_pkg.sv]
// constants, widths and state codes for the serial wiper register block
package iwr_pkg;
    // ****************************************
    // register layout
    // ****************************************
    localparam int WIPER_W = 7;                       // wiper code width
    localparam int TAP_N = 128;                       // ladder taps, one per code
    localparam logic [6:0] WIPER_DEFAULT = 7'h3f;     // mid-scale load on supply release
    localparam logic [6:0] WIPER_ZERO = 7'h00;        // zero-scale code, low-end terminal
    localparam logic [6:0] WIPER_FULL = 7'h7f;        // full-scale code, high-end terminal
    // ****************************************
    // serial bus framing
    // ****************************************
    localparam logic [6:0] SLAVE_ADDR = 7'h2f;        // fixed 7-bit slave address
    localparam logic [3:0] BIT_LAST = 4'h8;           // eight bits then the ack slot
    localparam logic [3:0] BIT_FIRST = 4'h0;          // bit counter start
    localparam int RW_POS = 0;                        // read/write flag in control byte
    localparam int MSB_POS = 7;                       // first bit on the wire
    // ****************************************
    // link state machine, gray along the path
    // ****************************************
    typedef enum logic [2:0] {
        IWR_IDLE = 3'h0,      // static, waiting for start
        IWR_ADDR = 3'h1,      // shifting control byte
        IWR_ADDR_ACK = 3'h3,  // driving address ack
        IWR_WR_DATA = 3'h2,   // shifting write byte
        IWR_WR_ACK = 3'h6,    // driving data ack
        IWR_RD_DATA = 3'h7,   // sending wiper byte
        IWR_RD_ACK = 3'h5,    // sampling master ack
        IWR_IGNORE = 3'h4     // fallen off the bus
    } iwr_state_t;
endpackage

// [design/iwr_top.sv]
// serial-bus slave holding one volatile wiper position register
`timescale 1ns/1ps
// Function
// - supply release loads mid-scale wiper code
// - supply low keeps serial interface disabled
// - stop enters static state, start leaves it
// - slave only, master supplies serial clock
// - 7-bit addressing, standard and fast rates
// - code zero selects zero-scale tap
// - maximum code selects full-scale tap
// - master can write and read wiper
// - data line open drain, sampled through two flops
// - brown-out mid command returns wiper to mid-scale
// - respond only to fixed slave address
// - never acknowledge general call address
// - never hold the clock line low
// - invalid command falls off until start
module iwr_top
#(
    parameter int WIPER_BITS = iwr_pkg::WIPER_W
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_n,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    output logic link_active,
    output logic [WIPER_BITS-1:0] wiper_position,
    output logic [iwr_pkg::TAP_N-1:0] tap_select
);
    import iwr_pkg::*;

    // ****************************************
    // link reset and pin synchronisers
    // ****************************************
    logic lrst_s1;                 // first stage, read only by link_rst_n
    logic link_rst_n;              // supply reset seen on link clock
    logic scl_s1, sda_s1;          // first stages
    logic scl_s, sda_s;            // synchronised pins
    logic scl_q, sda_q;            // previous synchronised samples

    // supply reset and pins reach the link domain through two flops
    always_ff @(posedge link_clk)
    begin
        lrst_s1 <= rst_n;
        link_rst_n <= lrst_s1;
        scl_s1 <= scl_in;
        sda_s1 <= sda_in;
        scl_s <= scl_s1;
        sda_s <= sda_s1;
        scl_q <= scl_s;
        sda_q <= sda_s;
    end

    // edge and condition decode, only from settled stages
    logic scl_rise, scl_fall, start_seen, stop_seen;
    assign scl_rise = scl_s & ~scl_q;
    assign scl_fall = ~scl_s & scl_q;
    assign start_seen = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_seen = scl_s & scl_q & ~sda_q & sda_s;

    // ****************************************
    // link state machine
    // ****************************************
    iwr_state_t state, next_state;
    logic [3:0] bit_cnt, next_bit_cnt;        // bits seen in current byte
    logic [7:0] shift, next_shift;            // receive shifter, also ack sample
    logic [7:0] tx, next_tx;                  // transmit shifter
    logic [WIPER_BITS-1:0] wiper_link, next_wiper_link; // link copy of wiper
    logic wr_tgl, next_wr_tgl;                // flips once per completed write
    logic drive_low, next_drive_low;          // pulling data line low
    logic active, next_active;                // serial interface active

    // next-state logic for the whole link side
    always_comb
    begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shift = shift;
        next_tx = tx;
        next_wiper_link = wiper_link;
        next_wr_tgl = wr_tgl;
        next_drive_low = drive_low;
        next_active = active;
        if (stop_seen)
        begin
            next_state = IWR_IDLE;
            next_active = 1'b0;
            next_drive_low = 1'b0;
        end
        else if (start_seen)
        begin
            // start (or repeated start) wakes the interface
            next_state = IWR_ADDR;
            next_active = 1'b1;
            next_bit_cnt = BIT_FIRST;
            next_drive_low = 1'b0;
        end
        else if (scl_rise)
        begin
            // master sets every bit time; nothing here ever drives the clock
            case (state)
                IWR_ADDR, IWR_WR_DATA, IWR_RD_DATA:
                begin
                    next_shift = {shift[6:0], sda_s};
                    next_bit_cnt = bit_cnt + 4'h1;
                end
                IWR_RD_ACK:
                    next_shift = {shift[6:0], sda_s};  // high means master nack
                default:
                    next_shift = shift;
            endcase
        end
        else if (scl_fall)
        begin
            case (state)
                IWR_ADDR:
                    if (bit_cnt == BIT_LAST)
                    begin
                        // only the fixed address; general call falls through
                        if (shift[7:1] == SLAVE_ADDR)
                        begin
                            next_state = IWR_ADDR_ACK;
                            next_drive_low = 1'b1;
                        end
                        else
                        begin
                            // foreign or bad address, drop off the bus
                            next_state = IWR_IGNORE;
                        end
                    end
                IWR_ADDR_ACK:
                begin
                    next_bit_cnt = BIT_FIRST;
                    if (shift[RW_POS])
                    begin
                        // read path, first bit out on this falling edge
                        next_state = IWR_RD_DATA;
                        next_tx = {1'b0, wiper_link};
                        // top bit of the read byte is always zero, so pull low
                        next_drive_low = 1'b1;
                    end
                    else
                    begin
                        next_state = IWR_WR_DATA;
                        next_drive_low = 1'b0;
                    end
                end
                IWR_WR_DATA:
                    if (bit_cnt == BIT_LAST)
                    begin
                        // write lands at the end of the data byte
                        // top bit of the byte has no tap and is dropped
                        next_wiper_link = shift[WIPER_BITS-1:0];
                        next_wr_tgl = ~wr_tgl;
                        next_state = IWR_WR_ACK;
                        next_drive_low = 1'b1;
                    end
                IWR_WR_ACK:
                begin
                    // further bytes keep overwriting the wiper
                    next_state = IWR_WR_DATA;
                    next_bit_cnt = BIT_FIRST;
                    next_drive_low = 1'b0;
                end
                IWR_RD_DATA:
                    if (bit_cnt == BIT_LAST)
                    begin
                        next_state = IWR_RD_ACK;
                        next_drive_low = 1'b0;
                    end
                    else
                    begin
                        next_tx = {tx[6:0], 1'b0};
                        next_drive_low = ~tx[MSB_POS-1];
                    end
                IWR_RD_ACK:
                    if (shift[0])
                    begin
                        // master nack ends the read, ignore until start
                        next_state = IWR_IGNORE;
                    end
                    else
                    begin
                        next_state = IWR_RD_DATA;
                        next_bit_cnt = BIT_FIRST;
                        next_tx = {1'b0, wiper_link};
                        next_drive_low = 1'b1;
                    end
                default:
                    next_drive_low = 1'b0;
            endcase
        end
    end

    // link registers; held idle and released while supply is low
    always_ff @(posedge link_clk)
    begin
        if (!link_rst_n)
        begin
            state <= IWR_IDLE;
            bit_cnt <= BIT_FIRST;
            shift <= '0;
            tx <= '0;
            // link copy starts at mid-scale too
            wiper_link <= WIPER_DEFAULT;
            wr_tgl <= 1'b0;
            drive_low <= 1'b0;
            active <= 1'b0;
        end
        else
        begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shift <= next_shift;
            tx <= next_tx;
            wiper_link <= next_wiper_link;
            wr_tgl <= next_wr_tgl;
            drive_low <= next_drive_low;
            active <= next_active;
        end
    end

    // data line only ever pulled low or released
    assign sda_out = 1'b0;
    assign sda_oe_n = ~drive_low;
    assign scl_out = 1'b0;
    assign scl_oe_n = 1'b1;
    assign link_active = active;

    // ****************************************
    // core wiper register, system clock
    // ****************************************
    logic tgl_s1, tgl_s2, tgl_q;                    // write toggle crossing
    logic [WIPER_BITS-1:0] next_wiper;
    logic [TAP_N-1:0] next_tap;
    logic wr_seen;
    assign wr_seen = tgl_s2 ^ tgl_q;

    // wiper_link is stable for a full byte time after the toggle, far longer
    // than the two-flop delay, so it is taken whole without its own sync
    always_comb
    begin
        next_wiper = wr_seen ? wiper_link : wiper_position;
        // zero-scale tap 0; full-scale tap top
        next_tap = '0;
        next_tap[next_wiper] = 1'b1;
    end

    // a brown-out mid command reloads the copy to mid-scale; no repair
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            tgl_s1 <= 1'b0;
            tgl_s2 <= 1'b0;
            tgl_q <= 1'b0;
            wiper_position <= WIPER_DEFAULT;
            tap_select <= TAP_N'(1) << WIPER_DEFAULT;
        end
        else
        begin
            tgl_s1 <= wr_tgl;
            tgl_s2 <= tgl_s1;
            tgl_q <= tgl_s2;
            wiper_position <= next_wiper;
            tap_select <= next_tap;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    sequence s_addr_done;
        scl_fall && !stop_seen && !start_seen && state == IWR_ADDR && bit_cnt == BIT_LAST;
    endsequence

    wiper_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> wiper_position == WIPER_DEFAULT && tap_select[WIPER_DEFAULT])
        else $error("wiper not mid-scale after reset");
    supply_quiet_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        $rose(link_rst_n) |-> sda_oe_n && state == IWR_IDLE)
        else $error("interface not quiet out of reset");
    stop_static_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        stop_seen |=> !link_active && sda_oe_n)
        else $error("stop did not enter static state");
    start_wake_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        start_seen && !stop_seen |=> link_active && state == IWR_ADDR)
        else $error("start did not wake interface");
    addr_ack_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        s_addr_done ##0 (shift[7:1] == SLAVE_ADDR) |=> !sda_oe_n && state == IWR_ADDR_ACK)
        else $error("own address not acknowledged");
    general_call_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        s_addr_done ##0 (shift[7:1] == 7'h00) |=> sda_oe_n [*2])
        else $error("general call acknowledged");
    ignore_quiet_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        state == IWR_IGNORE && !start_seen |=> sda_oe_n)
        else $error("data driven while ignoring bus");
    drive_slot_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        !sda_oe_n |-> state inside {IWR_ADDR_ACK, IWR_WR_ACK, IWR_RD_DATA})
        else $error("data line driven outside a slot");
    no_stretch_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        link_active |-> scl_oe_n)
        else $error("clock line held low");
    write_cross_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_seen |=> wiper_position == $past(wiper_link))
        else $error("write did not reach wiper");
    tap_onehot_a: assert property (@(posedge clk) disable iff (!rst_n)
        $onehot(tap_select) && tap_select[wiper_position]
        && (wiper_position == WIPER_ZERO) == tap_select[0]
        && (wiper_position == WIPER_FULL) == tap_select[TAP_N-1])
        else $error("tap select not one per code");
endmodule

// [test/iwr_master.sv]
// two-wire bus master model that drives the serial clock and data lines
`timescale 1ns/1ps
module iwr_master
#(
    parameter int HALF = 50
)
(
    input wire logic clk,
    input wire logic sda_line,
    output logic scl_m,
    output logic sda_m
);
    // ****************************************
    // line drivers
    // ****************************************
    // both lines released while no frame runs
    initial
    begin
        scl_m = 1'b1;
        sda_m = 1'b1;
    end
    // wait n system cycles, moving only on the falling edge
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask
    // master makes every clock pulse, 400 kHz at HALF 50
    // data moves mid-low so it never races the clock edge
    task automatic bit_io(input logic b, output logic r);
        wait_n(HALF / 2);
        sda_m = b;
        wait_n(HALF / 2);
        scl_m = 1'b1;
        wait_n(HALF);
        r = sda_line;
        scl_m = 1'b0;
    endtask
    // start or repeated start, works from idle or mid-frame
    task automatic start();
        wait_n(HALF / 2);
        sda_m = 1'b1;
        wait_n(HALF / 2);
        scl_m = 1'b1;
        wait_n(HALF);
        sda_m = 1'b0;
        wait_n(HALF);
        scl_m = 1'b0;
    endtask
    // stop leaves both lines high, clock standing still
    task automatic stop();
        wait_n(HALF / 2);
        sda_m = 1'b0;
        wait_n(HALF / 2);
        scl_m = 1'b1;
        wait_n(HALF);
        sda_m = 1'b1;
        wait_n(HALF);
    endtask
    // write one byte, control or data, MSB first, then ack slot
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r);
        bit_io(1'b1, ack);
    endtask
    // read one byte, then ack (last = 0) or nack (last = 1)
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(last, r);
    endtask
endmodule

// [test/iwr_top_tb_top.sv]
// self-checking bench for the serial wiper register block
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
    $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module iwr_top_tb_top;
    import iwr_pkg::*;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n = 1'b0;
    logic scl_m, sda_m, scl_out, scl_oe_n, sda_out, sda_oe_n, link_active;
    logic [6:0] wiper_position;
    logic [127:0] tap_select;
    logic a0, a1, a2;
    logic [7:0] rb;
    int failures = 0;
    int n_checks = 0;
    int cyc = 0;
    // wired-AND with pull-up: a party pulls low only while enabled
    wire scl_line = scl_m & (scl_oe_n ? 1'b1 : scl_out);
    wire sda_line = sda_m & (sda_oe_n ? 1'b1 : sda_out);
    // ****************************************
    // clocks, design and master
    // ****************************************
    always #12.5 clk = ~clk;
    // link clock offset by 7 so its edges line up with clk only once every 600 ns
    initial
    begin
        #7;
        forever #24 link_clk = ~link_clk;
    end
    iwr_top uut (.clk(clk), .rst_n(rst_n), .link_clk(link_clk), .scl_in(scl_line),
        .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .link_active(link_active), .wiper_position(wiper_position),
        .tap_select(tap_select));
    iwr_master #(.HALF(50)) m (.clk(clk), .sda_line(sda_line), .scl_m(scl_m), .sda_m(sda_m));
    // ****************************************
    // pin watch and timeout
    // ****************************************
    // clock pin never pulled, data pin only ever pulled low
    always @(negedge clk)
    begin
        `CHK(scl_oe_n, 1'b1)
        `CHK(scl_out, 1'b0)
        if (sda_oe_n === 1'b0)
            `CHK(sda_out, 1'b0)
    end
    // a whole run is about 23k cycles, so 60k cycles means a hang
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            failures++;
            finish_test();
        end
    end
    // ****************************************
    // tasks
    // ****************************************
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // whole write frame, two data bytes, the second one wins
    task automatic wframe(input logic [7:0] ad, input logic [7:0] d0, input logic [7:0] d1);
        m.start();
        m.wr_byte(ad, a0);
        m.wr_byte(d0, a1);
        m.wr_byte(d1, a2);
        m.stop();
    endtask
    // supply drop; link side needs two of its own periods to see it
    task automatic supply_cycle();
        rst_n = 1'b0;
        m.wait_n(10);
        rst_n = 1'b1;
        m.wait_n(12);
    endtask
    // ****************************************
    // test sequence
    // ****************************************
    initial
    begin
        m.wait_n(10);
        `CHK(wiper_position, WIPER_DEFAULT)
        `CHK(tap_select, 128'h1 << 63)
        `CHK(link_active, 1'b0)
        wframe(8'h5e, 8'h10, 8'h10);
        `CHK(a0, 1'b1)
        `CHK(wiper_position, WIPER_DEFAULT)
        rst_n = 1'b1;
        m.wait_n(12);
        $display("test reset done");
        wframe(8'h5e, 8'h55, 8'h00);
        `CHK({a0, a1, a2}, 3'h0)
        `CHK(wiper_position, WIPER_ZERO)
        `CHK(tap_select, 128'h1)
        `CHK(link_active, 1'b0)
        wframe(8'h5e, 8'hff, 8'hff);
        `CHK(wiper_position, WIPER_FULL)
        `CHK(tap_select, 128'h1 << 127)
        $display("test write done");
        m.start();
        `CHK(link_active, 1'b1)
        m.wr_byte(8'h5f, a0);
        m.rd_byte(1'b0, rb);
        `CHK(rb, 8'h7f)
        m.rd_byte(1'b1, rb);
        `CHK(rb, 8'h7f)
        m.stop();
        `CHK(a0, 1'b0)
        `CHK(link_active, 1'b0)
        $display("test read done");
        wframe(8'h5c, 8'h15, 8'h15);
        `CHK({a0, a1, a2}, 3'h7)
        wframe(8'h00, 8'h33, 8'h33);
        `CHK({a0, a1}, 2'h3)
        `CHK(wiper_position, WIPER_FULL)
        m.start();
        m.wr_byte(8'h5c, a0);
        m.start();
        m.wr_byte(8'h5e, a1);
        m.wr_byte(8'h2a, a2);
        m.stop();
        `CHK({a0, a1, a2}, 3'h4)
        `CHK(wiper_position, 7'h2a)
        $display("test refuse done");
        m.start();
        m.wr_byte(8'h5e, a0);
        supply_cycle();
        m.wr_byte(8'h44, a1);
        m.stop();
        `CHK(a1, 1'b1)
        `CHK(wiper_position, WIPER_DEFAULT)
        $display("test brownout done");
        finish_test();
    end
endmodule
